// file: hw/spu_regs.vh
// constants for the stack store and stack load unit
`ifndef SPU_REGS_VH
`define SPU_REGS_VH

// ==================================================
// opcode encodings
`define SPU_OP_PREFIX_X 8'hdd
`define SPU_OP_PREFIX_Y 8'hfd
`define SPU_OP_IDX_STORE 8'he5
`define SPU_OP_IDX_LOAD 8'he1
`define SPU_OP_GROUP 2'h3
`define SPU_OP_STORE_LOW 4'h5
`define SPU_OP_LOAD_LOW 4'h1

// ==================================================
// operand word selectors in the pair file
`define SPU_SEL_FIRST 3'h0
`define SPU_SEL_SECOND 3'h1
`define SPU_SEL_THIRD 3'h2
`define SPU_SEL_ACCFLAGS 3'h3
`define SPU_SEL_IDX_X 3'h4
`define SPU_SEL_IDX_Y 3'h5

// ==================================================
// prefix tracking
`define SPU_PFX_NONE 2'h0
`define SPU_PFX_X 2'h1
`define SPU_PFX_Y 2'h2

// ==================================================
// clock-state counts, one sys_clk edge per state
`define SPU_T_M1_STORE 3'h5
`define SPU_T_M1_STD 3'h4
`define SPU_T_MEM 3'h3
`define SPU_T_FETCH_OFS 3'h2
`define SPU_T_ONE 3'h1
`define SPU_T_ZERO 3'h0

// ==================================================
// stack pointer step and reset
`define SPU_SP_STEP 16'h0001
`define SPU_SP_RESET 16'hffff

// ==================================================
// opcode and word fields
`define SPU_OP_GRP_F 7:6
`define SPU_OP_SEL_F 5:4
`define SPU_OP_LOW_F 3:0
`define SPU_HI_BYTE_F 15:8
`define SPU_LO_BYTE_F 7:0

// ==================================================
// reset values and pair file shape
`define SPU_BYTE_RESET 8'h00
`define SPU_ADDR_RESET 16'h0000
`define SPU_FILE_DEPTH 6
`define SPU_FILE_AW 3

`endif

// file: hw/spu_pair_file.v
// register pair storage with registered read data
`timescale 1ns/1ps
module spu_pair_file #(
    parameter WIDTH = 16,
    parameter DEPTH = 6,
    parameter AW = 3
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [AW-1:0] rdAddr,
    output reg [WIDTH-1:0] rdData,
    input wire wrEn,
    input wire [AW-1:0] wrAddr,
    input wire [WIDTH-1:0] wrData
);

// ==================================================
// storage
reg [WIDTH-1:0] mem [0:DEPTH-1];

always @(posedge sys_clk) begin
    if (wrEn) begin
        mem[wrAddr] <= wrData;
    end
end

// read data reset only; contents are software-defined before use
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        rdData <= {WIDTH{1'b0}};
    end else begin
        rdData <= mem[rdAddr];
    end
end

endmodule // spu_pair_file

// file: hw/spu_stack_unit.v
// stack store / stack load decode and execution engine
//
// Overview of operation
// RL1 - 16-bit stack pointer addresses top of stack; stack grows downward in memory.
// RL2 - single-byte store/load opcode bits 5:4 pick first, second, third, accum-flags pair.
// RL3 - pair store: decrement, write high; decrement, write low; 11 states 5,3,3.
// RL4 - prefix DD then E5 stores index x, high first, 15 states 4,5,3,3.
// RL5 - prefix FD then E5 stores index y, same order, 15 states.
// RL6 - pair load shares select bits, low nibble differs; 10 states 4,3,3.
// RL7 - pair load: read low at pointer, increment; read high, increment.
// RL8 - prefix DD then E1 loads index x, low then high, 14 states.
// RL9 - prefix FD loads index y, low then high, 14 states.
// RL10 - flags untouched except when accum-flags pair itself is reloaded.
// RL11 - index y load second byte is E1, same as index x form.
// RL12 - stack pointer steps wrap modulo 65536 silently.
`timescale 1ns/1ps
`include "spu_regs.vh"
module spu_stack_unit #(
    parameter WIDTH = 16
) (
    input wire sys_clk,
    input wire rst_n,
    input wire opValid,
    input wire [7:0] opByte,
    output reg opReady_reg,
    output reg done_reg,
    output reg illegal_reg,
    output reg busy_reg,
    input wire spWrEn,
    input wire [WIDTH-1:0] spWrData,
    output reg [WIDTH-1:0] stackPointer_reg,
    input wire regWrEn,
    input wire [2:0] regWrSel,
    input wire [WIDTH-1:0] regWrData,
    input wire [2:0] regRdSel,
    output wire [WIDTH-1:0] regRdData,
    output reg [WIDTH-1:0] memAddr_reg,
    output reg [7:0] memWrData_reg,
    output reg memWr_reg,
    output reg memRd_reg,
    input wire [7:0] memRdData
);

// ==================================================
// states
localparam S_IDLE = 3'h0;
localparam S_FETCH = 3'h1;
localparam S_WHI = 3'h2;
localparam S_WLO = 3'h3;
localparam S_RLO = 3'h4;
localparam S_RHI = 3'h5;

localparam K_PREFIX = 2'h0;
localparam K_STORE = 2'h1;
localparam K_LOAD = 2'h2;

// ==================================================
// decode helpers
function isStore;
    input [7:0] b;
    begin
        isStore = (b[`SPU_OP_GRP_F] == `SPU_OP_GROUP) &&
            (b[`SPU_OP_LOW_F] == `SPU_OP_STORE_LOW); // RL2
    end
endfunction

function isLoad;
    input [7:0] b;
    begin
        isLoad = (b[`SPU_OP_GRP_F] == `SPU_OP_GROUP) &&
            (b[`SPU_OP_LOW_F] == `SPU_OP_LOAD_LOW); // RL6
    end
endfunction

function isPrefix;
    input [7:0] b;
    begin
        isPrefix = (b == `SPU_OP_PREFIX_X) || (b == `SPU_OP_PREFIX_Y);
    end
endfunction

// ==================================================
// registers
reg [2:0] state_reg, state_next;
reg [2:0] tCount_reg, tCount_next;
reg [1:0] kind_reg, kind_next;
reg [1:0] prefix_reg, prefix_next;
reg [2:0] sel_reg, sel_next;
reg [7:0] lowByte_reg, lowByte_next;
reg [WIDTH-1:0] sp_next;
reg [WIDTH-1:0] memAddr_next;
reg [7:0] memWrData_next;
reg memWr_next, memRd_next, opReady_next, done_next, illegal_next;
reg [7:0] rdSync1_reg, rdSync2_reg;
reg engWrEn;
reg [WIDTH-1:0] engWrData;

wire idle = (state_reg == S_IDLE);
wire take = idle && opValid && opReady_reg;
wire lastState = (tCount_reg == `SPU_T_ZERO);
wire [WIDTH-1:0] srcWord;

// core access only while idle so the engine owns the file mid-instruction
wire fileWrEn = engWrEn || (idle && regWrEn);
wire [2:0] fileWrSel = engWrEn ? sel_reg : regWrSel;
wire [WIDTH-1:0] fileWrData = engWrEn ? engWrData : regWrData;
wire [2:0] fileRdSel = idle ? regRdSel : sel_reg;

assign regRdData = srcWord;

spu_pair_file #(
    .WIDTH(WIDTH),
    .DEPTH(`SPU_FILE_DEPTH),
    .AW(`SPU_FILE_AW)
) pairFile (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .rdAddr(fileRdSel),
    .rdData(srcWord),
    .wrEn(fileWrEn),
    .wrAddr(fileWrSel),
    .wrData(fileWrData)
);

// ==================================================
// read data synchroniser; memory must present data in the first state
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        rdSync1_reg <= `SPU_BYTE_RESET;
        rdSync2_reg <= `SPU_BYTE_RESET;
    end else begin
        rdSync1_reg <= memRdData;
        rdSync2_reg <= rdSync1_reg;
    end
end

// ==================================================
// sequencer
always @* begin
    state_next = state_reg;
    tCount_next = tCount_reg;
    kind_next = kind_reg;
    prefix_next = prefix_reg;
    sel_next = sel_reg;
    lowByte_next = lowByte_reg;
    sp_next = stackPointer_reg;
    memAddr_next = memAddr_reg;
    memWrData_next = memWrData_reg;
    memWr_next = memWr_reg;
    memRd_next = memRd_reg;
    opReady_next = opReady_reg;
    done_next = 1'b0;
    illegal_next = 1'b0;
    engWrEn = 1'b0;
    engWrData = {rdSync2_reg, lowByte_reg};
    case (state_reg)
        S_IDLE: begin
            if (spWrEn) begin
                sp_next = spWrData;
            end
            if (take) begin
                if (isPrefix(opByte)) begin
                    // a second prefix simply replaces the first
                    prefix_next = (opByte == `SPU_OP_PREFIX_X) ? `SPU_PFX_X : `SPU_PFX_Y;
                    kind_next = K_PREFIX;
                    tCount_next = `SPU_T_M1_STD - `SPU_T_FETCH_OFS;
                    opReady_next = 1'b0;
                    state_next = S_FETCH;
                end else if (prefix_reg != `SPU_PFX_NONE) begin
                    if (opByte == `SPU_OP_IDX_STORE || opByte == `SPU_OP_IDX_LOAD) begin // RL11
                        sel_next = (prefix_reg == `SPU_PFX_X) ? `SPU_SEL_IDX_X :
                            `SPU_SEL_IDX_Y; // RL4 RL5 RL8 RL9
                        kind_next = (opByte == `SPU_OP_IDX_STORE) ? K_STORE : K_LOAD;
                        tCount_next = ((opByte == `SPU_OP_IDX_STORE) ? `SPU_T_M1_STORE :
                            `SPU_T_M1_STD) - `SPU_T_FETCH_OFS; // RL4 RL8
                        opReady_next = 1'b0;
                        state_next = S_FETCH;
                    end else begin
                        illegal_next = 1'b1;
                        prefix_next = `SPU_PFX_NONE;
                    end
                end else if (isStore(opByte) || isLoad(opByte)) begin
                    sel_next = {1'b0, opByte[`SPU_OP_SEL_F]}; // RL2
                    kind_next = isStore(opByte) ? K_STORE : K_LOAD;
                    tCount_next = (isStore(opByte) ? `SPU_T_M1_STORE : `SPU_T_M1_STD) -
                        `SPU_T_FETCH_OFS; // RL3 RL6
                    opReady_next = 1'b0;
                    state_next = S_FETCH;
                end else begin
                    illegal_next = 1'b1;
                end
            end
        end
        S_FETCH: begin
            if (!lastState) begin
                tCount_next = tCount_reg - `SPU_T_ONE;
            end else if (kind_reg == K_PREFIX) begin
                opReady_next = 1'b1;
                state_next = S_IDLE;
            end else if (kind_reg == K_STORE) begin
                // decrement first, then write the high byte there
                sp_next = stackPointer_reg - `SPU_SP_STEP; // RL1 RL3 RL12
                memAddr_next = stackPointer_reg - `SPU_SP_STEP;
                memWrData_next = srcWord[`SPU_HI_BYTE_F];
                memWr_next = 1'b1;
                tCount_next = `SPU_T_MEM - `SPU_T_ONE;
                state_next = S_WHI;
            end else begin
                memAddr_next = stackPointer_reg; // RL7
                memRd_next = 1'b1;
                tCount_next = `SPU_T_MEM - `SPU_T_ONE;
                state_next = S_RLO;
            end
        end
        S_WHI: begin
            if (!lastState) begin
                tCount_next = tCount_reg - `SPU_T_ONE;
            end else begin
                sp_next = stackPointer_reg - `SPU_SP_STEP; // RL3 RL12
                memAddr_next = stackPointer_reg - `SPU_SP_STEP;
                memWrData_next = srcWord[`SPU_LO_BYTE_F];
                tCount_next = `SPU_T_MEM - `SPU_T_ONE;
                state_next = S_WLO;
            end
        end
        S_WLO: begin
            if (!lastState) begin
                tCount_next = tCount_reg - `SPU_T_ONE;
            end else begin
                memWr_next = 1'b0;
                done_next = 1'b1;
                opReady_next = 1'b1;
                prefix_next = `SPU_PFX_NONE;
                state_next = S_IDLE;
            end
        end
        S_RLO: begin
            if (!lastState) begin
                tCount_next = tCount_reg - `SPU_T_ONE;
            end else begin
                lowByte_next = rdSync2_reg; // RL7
                sp_next = stackPointer_reg + `SPU_SP_STEP; // RL12
                memAddr_next = stackPointer_reg + `SPU_SP_STEP;
                tCount_next = `SPU_T_MEM - `SPU_T_ONE;
                state_next = S_RHI;
            end
        end
        S_RHI: begin
            if (!lastState) begin
                tCount_next = tCount_reg - `SPU_T_ONE;
            end else begin
                // only the selected word changes; flags move only inside accum-flags
                engWrEn = 1'b1; // RL7 RL10
                sp_next = stackPointer_reg + `SPU_SP_STEP; // RL12
                memRd_next = 1'b0;
                done_next = 1'b1;
                opReady_next = 1'b1;
                prefix_next = `SPU_PFX_NONE;
                state_next = S_IDLE;
            end
        end
        default: begin
            memWr_next = 1'b0;
            memRd_next = 1'b0;
            opReady_next = 1'b1;
            prefix_next = `SPU_PFX_NONE;
            state_next = S_IDLE;
        end
    endcase
end

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        state_reg <= S_IDLE;
        tCount_reg <= `SPU_T_ZERO;
        kind_reg <= K_PREFIX;
        prefix_reg <= `SPU_PFX_NONE;
        sel_reg <= `SPU_SEL_FIRST;
        lowByte_reg <= `SPU_BYTE_RESET;
        stackPointer_reg <= `SPU_SP_RESET;
        memAddr_reg <= `SPU_ADDR_RESET;
        memWrData_reg <= `SPU_BYTE_RESET;
        memWr_reg <= 1'b0;
        memRd_reg <= 1'b0;
        opReady_reg <= 1'b1;
        done_reg <= 1'b0;
        illegal_reg <= 1'b0;
        busy_reg <= 1'b0;
    end else begin
        state_reg <= state_next;
        tCount_reg <= tCount_next;
        kind_reg <= kind_next;
        prefix_reg <= prefix_next;
        sel_reg <= sel_next;
        lowByte_reg <= lowByte_next;
        stackPointer_reg <= sp_next;
        memAddr_reg <= memAddr_next;
        memWrData_reg <= memWrData_next;
        memWr_reg <= memWr_next;
        memRd_reg <= memRd_next;
        opReady_reg <= opReady_next;
        done_reg <= done_next;
        illegal_reg <= illegal_next;
        busy_reg <= (state_next != S_IDLE);
    end
end

endmodule // spu_stack_unit

// file: sim/spu_stack_unit_assertions.sv
// port-level timing checks for the stack unit
`timescale 1ns/1ps
module spu_stack_unit_chk #(
    parameter WIDTH = 16
) (
    input wire sys_clk,
    input wire rst_n,
    input wire opValid,
    input wire [7:0] opByte,
    input wire opReady_reg,
    input wire done_reg,
    input wire illegal_reg,
    input wire [WIDTH-1:0] stackPointer_reg,
    input wire [WIDTH-1:0] memAddr_reg,
    input wire [7:0] memWrData_reg,
    input wire memWr_reg,
    input wire memRd_reg
);
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!rst_n);
// ==================================================
// helpers
wire take = opValid && opReady_reg;
reg pfxSeen;
// a byte after a prefix only counts when it is the index form
wire okByte = !pfxSeen || opByte == 8'he5 || opByte == 8'he1;
always @(posedge sys_clk or negedge rst_n)
    if (!rst_n) pfxSeen <= 1'b0;
    else if (take) pfxSeen <= opByte == 8'hdd || opByte == 8'hfd;
sequence store_take_s; take && okByte && opByte[7:6] == 2'h3 && opByte[3:0] == 4'h5; endsequence
sequence load_take_s; take && okByte && opByte[7:6] == 2'h3 && opByte[3:0] == 4'h1; endsequence
sequence pfx_take_s; take && (opByte == 8'hdd || opByte == 8'hfd); endsequence
sequence byte_out_s; memWr_reg ##1 memWr_reg ##1 memWr_reg; endsequence
// ==================================================
// checks
store_len_a: assert property (store_take_s |=> !opReady_reg ##10 done_reg)
    else $error("store length wrong");
load_len_a: assert property (load_take_s |=> !opReady_reg ##9 done_reg)
    else $error("load length wrong");
prefix_wait_a: assert property (pfx_take_s |=> !opReady_reg[*3] ##1 opReady_reg)
    else $error("prefix states wrong");
illegal_flag_a: assert property (take && opByte[7:6] != 2'h3 |=> illegal_reg && opReady_reg)
    else $error("bad byte not flagged");
push_addr_a: assert property ($rose(memWr_reg) |-> memAddr_reg == stackPointer_reg
    && stackPointer_reg == $past(stackPointer_reg) - 16'h0001)
    else $error("push not decrement then write");
second_byte_a: assert property ($rose(memWr_reg) |-> byte_out_s
    ##1 (memWr_reg && memAddr_reg == $past(memAddr_reg, 3) - 16'h0001))
    else $error("low byte not one below");
write_stable_a: assert property ($rose(memWr_reg)
    |=> ($stable(memAddr_reg) && $stable(memWrData_reg))[*2])
    else $error("write byte unstable");
pop_addr_a: assert property ($rose(memRd_reg) |-> memAddr_reg == stackPointer_reg)
    else $error("pop does not read at pointer");
pop_step_a: assert property ($fell(memRd_reg)
    |-> stackPointer_reg == $past(stackPointer_reg, 6) + 16'h0002)
    else $error("pop pointer step wrong");
bus_excl_a: assert property (!(memWr_reg && memRd_reg))
    else $error("read and write together");
done_pulse_a: assert property (done_reg |=> !done_reg)
    else $error("done longer than one cycle");
endmodule // spu_stack_unit_chk
bind spu_stack_unit spu_stack_unit_chk #(.WIDTH(WIDTH)) chk (.sys_clk, .rst_n, .opValid,
    .opByte, .opReady_reg, .done_reg, .illegal_reg, .stackPointer_reg, .memAddr_reg,
    .memWrData_reg, .memWr_reg, .memRd_reg);

// file: sim/spu_stack_mem.sv
// zero-wait byte memory that holds the stack
`timescale 1ns/1ps
module spu_stack_mem (
    input wire sys_clk,
    input wire [15:0] memAddr_reg,
    input wire [7:0] memWrData_reg,
    input wire memWr_reg,
    input wire memRd_reg,
    output wire [7:0] memRdData
);
reg [7:0] mem [0:65535];
reg [7:0] lastByte = 8'h00;
// idle bus shows the inverse of the last byte so stale data never passes
assign memRdData = memRd_reg ? mem[memAddr_reg] : ~lastByte;
always @(posedge sys_clk) begin
    if (memWr_reg) mem[memAddr_reg] <= memWrData_reg;
    if (memRd_reg) lastByte <= mem[memAddr_reg];
end
endmodule // spu_stack_mem

// file: sim/tb_top.sv
// self-checking bench for the stack unit
`timescale 1ns/1ps
module tb_top;
reg sys_clk = 0, rst_n = 0, opValid = 0, spWrEn = 0, regWrEn = 0;
reg [7:0] opByte = 8'h00;
reg [15:0] spWrData = 16'h0000, regWrData = 16'h0000;
reg [2:0] regWrSel = 3'h0, regRdSel = 3'h0;
logic busyAtTake;
wire opReady_reg, done_reg, illegal_reg, busy_reg, memWr_reg, memRd_reg;
wire [15:0] stackPointer_reg, regRdData, memAddr_reg;
wire [7:0] memWrData_reg, memRdData;
int bad_count = 0, check_count = 0, n, sp;
int pairs [0:5];
int stk [$];
always #4 sys_clk = ~sys_clk;
spu_stack_unit dut (.sys_clk, .rst_n, .opValid, .opByte, .opReady_reg, .done_reg,
    .illegal_reg, .busy_reg, .spWrEn, .spWrData, .stackPointer_reg, .regWrEn, .regWrSel,
    .regWrData, .regRdSel, .regRdData, .memAddr_reg, .memWrData_reg, .memWr_reg,
    .memRd_reg, .memRdData);
spu_stack_mem stackMem (.sys_clk, .memAddr_reg, .memWrData_reg, .memWr_reg, .memRd_reg,
    .memRdData);
// ==================================================
// tasks, all entered at a falling edge
task chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
        bad_count++;
        $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
endtask
task end_sim;
    if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
task send(input [7:0] b);
    opByte = b;
    opValid = 1;
    @(negedge sys_clk);
    opValid = 0;
    busyAtTake = busy_reg;
    n = 1;
    while (done_reg !== 1'b1 && opReady_reg !== 1'b1 && n < 40) begin
        @(negedge sys_clk);
        n++;
    end
endtask
task op(input [7:0] pfx, input [7:0] b, input int total);
    if (pfx != 8'h00) begin
        send(pfx);
        chk(n[15:0], 16'h0004);
        total = total - 4;
    end
    send(b);
    chk(n[15:0], total[15:0]);
    chk({15'h0, busyAtTake}, 16'h0001);
    chk({15'h0, done_reg}, 16'h0001);
    chk({15'h0, busy_reg}, 16'h0000);
endtask
task wr(input int s, input int v);
    regWrEn = 1;
    regWrSel = s[2:0];
    regWrData = v[15:0];
    @(negedge sys_clk);
    regWrEn = 0;
    pairs[s] = v & 16'hffff;
endtask
task setsp(input int v);
    spWrEn = 1;
    spWrData = v[15:0];
    @(negedge sys_clk);
    spWrEn = 0;
    sp = v;
endtask
task rd(input int s);
    regRdSel = s[2:0];
    repeat (3) @(negedge sys_clk);
    chk(regRdData, pairs[s][15:0]);
endtask
task push(input int s);
    if (s < 4) op(8'h00, {2'b11, s[1:0], 4'h5}, 11);
    else op(s == 4 ? 8'hdd : 8'hfd, 8'he5, 15);
    sp = (sp - 2) & 16'hffff;
    stk.push_back(pairs[s]);
    chk(stackPointer_reg, sp[15:0]);
    chk({stackMem.mem[(sp + 1) & 16'hffff], stackMem.mem[sp]}, pairs[s][15:0]);
endtask
task pop(input int s);
    if (s < 4) op(8'h00, {2'b11, s[1:0], 4'h1}, 10);
    else op(s == 4 ? 8'hdd : 8'hfd, 8'he1, 14);
    pairs[s] = stk.pop_back();
    sp = (sp + 2) & 16'hffff;
    chk(stackPointer_reg, sp[15:0]);
    rd(s);
endtask
// ==================================================
// main sequence
initial begin
    void'($urandom(32'h4da7));
    repeat (5) @(negedge sys_clk);
    rst_n = 1;
    chk(stackPointer_reg, 16'hffff);
    chk({15'h0, opReady_reg}, 16'h0001);
    setsp(16'h1007);
    for (int i = 0; i < 6; i++) wr(i, $urandom);
    for (int i = 0; i < 6; i++) push(i);
    // pop into other pairs so each lands in a new place
    for (int i = 5; i >= 0; i--) pop(5 - i);
    setsp(16'h0001);
    push(2);
    pop(3);
    send(8'hdd);
    push(5);
    pop(4);
    send(8'h07);
    chk({15'h0, illegal_reg}, 16'h0001);
    send(8'hdd);
    send(8'h07);
    chk({15'h0, illegal_reg}, 16'h0001);
    // prefix must be dropped, so this is a plain pair store
    push(1);
    pop(1);
    // every word must still match the model, accum-flags included
    for (int i = 0; i < 6; i++) rd(i);
    end_sim;
end
initial begin
    #100000;
    bad_count++;
    end_sim;
end
endmodule // tb_top
